// File: verilog/frt_timer.sv
// Purpose: 16-bit free-running timer with capture, compare and overflow.
// Assumes: APB slave on pclk; capture pin is asynchronous to pclk.
// Notes: Read side effects act at the setup edge, writes at the access edge.
`timescale 1ns/1ps

module frt_timer
  import frt_pkg::*;
#(
  parameter int STARTUP_CYCLES = FRT_STARTUP_DEF
) (
  input logic pclk,
  input logic presetn,
  input logic pclk_en,
  input frt_apb_req_t apb_req,
  output frt_apb_rsp_t apb_rsp,
  input logic capture_input_pin,
  output logic compare_output_pin,
  output logic timer_irq
);

  frt_state_t state_ff;
  frt_state_t nxt_state;

  // Word index of an APB address.
  function automatic logic [5:0] frt_index(input logic [7:0] addr);
    frt_index = addr[7:2];
  endfunction

  // An address hits when word aligned and inside the timer window.
  function automatic logic frt_hit(input logic [7:0] addr);
    logic [5:0] i;
    i = addr[7:2];
    frt_hit = (addr[1:0] == 2'h0) && (i >= FRT_IDX_CTRL) && (i <= FRT_IDX_ALT_LO);
  endfunction

  // Byte returned by a read; low counter bytes use the frozen buffer while it is valid, else the live count.
  function automatic logic [7:0] frt_rbyte(input frt_state_t s, input logic [5:0] i);
    logic [7:0] r;
    r = 8'h00;
    case (i)
      FRT_IDX_CTRL: r = s.ctrl & FRT_CTRL_WMASK;
      FRT_IDX_STAT: r = {s.icf, s.ocf, s.ovf, 5'h00};
      FRT_IDX_CAP_HI: r = s.capture[15:8];
      FRT_IDX_CAP_LO: r = s.capture[7:0];
      FRT_IDX_CMP_HI: r = s.compare[15:8];
      FRT_IDX_CMP_LO: r = s.compare[7:0];
      FRT_IDX_CNT_HI, FRT_IDX_ALT_HI: r = s.count[15:8];
      FRT_IDX_CNT_LO, FRT_IDX_ALT_LO: r = s.buf_valid ? s.buf_lo : s.count[7:0];
      default: r = 8'h00;
    endcase
    frt_rbyte = r;
  endfunction

  logic [5:0] idx;
  logic hit;
  logic setup;
  logic rd_setup;
  logic wr_access;
  logic tick;
  logic wrap;
  logic cap_edge;
  logic match;
  logic cnt_hi_rd;
  logic cnt_lo_rd;

  // Bus phase decode and timer events seen in this cycle.
  assign idx = frt_index(apb_req.paddr);
  assign hit = frt_hit(apb_req.paddr);
  assign setup = apb_req.psel && !apb_req.penable && !state_ff.rsp.pready;
  assign rd_setup = setup && hit && !apb_req.pwrite;
  assign wr_access = apb_req.psel && apb_req.penable && state_ff.rsp.pready && hit && apb_req.pwrite;
  assign tick = state_ff.started && (state_ff.psc == FRT_PSC_LAST);
  assign wrap = tick && (state_ff.count == FRT_CNT_WRAP);
  assign cap_edge = (state_ff.cap_sync[1] != state_ff.cap_sync[2])
    && (state_ff.cap_sync[1] == state_ff.ctrl[FRT_BIT_EDGE]);
  assign match = tick && !state_ff.cmp_inhibit && ((state_ff.count + FRT_CNT_ONE) == state_ff.compare);
  // Both views decode to the same counter bytes; only the low-byte side effects differ.
  assign cnt_hi_rd = rd_setup && ((idx == FRT_IDX_CNT_HI) || (idx == FRT_IDX_ALT_HI));
  assign cnt_lo_rd = rd_setup && ((idx == FRT_IDX_CNT_LO) || (idx == FRT_IDX_ALT_LO));

  // Next state. Clears are applied first and sets last, so an event in
  // the same cycle as its clearing access is never lost.
  always_comb begin
    nxt_state = state_ff;
    // APB answer: one wait-free access phase after every setup.
    nxt_state.rsp.pready = setup;
    if (setup) begin
      nxt_state.rsp.pslverr = !hit;
      nxt_state.rsp.prdata = (hit && !apb_req.pwrite) ? {24'h00_0000, frt_rbyte(state_ff, idx)} : 32'h0000_0000;
    end
    // Read side effects; the counter value itself is never touched.
    if (rd_setup) begin
      case (idx)
        FRT_IDX_STAT: begin
          nxt_state.icf_arm = state_ff.icf;
          nxt_state.ocf_arm = state_ff.ocf;
          nxt_state.ovf_arm = state_ff.ovf;
        end
        FRT_IDX_CAP_HI: nxt_state.cap_inhibit = 1'b1;
        FRT_IDX_CAP_LO: begin
          nxt_state.cap_inhibit = 1'b0;
          if (state_ff.icf_arm) begin
            nxt_state.icf = 1'b0;
            nxt_state.icf_arm = 1'b0;
          end
        end
        FRT_IDX_CMP_LO: begin
          if (state_ff.ocf_arm) begin
            nxt_state.ocf = 1'b0;
            nxt_state.ocf_arm = 1'b0;
          end
        end
        FRT_IDX_CNT_LO: begin
          if (state_ff.ovf_arm) begin
            nxt_state.ovf = 1'b0;
            nxt_state.ovf_arm = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // The alternate low byte only releases the buffer, it never clears.
    if (cnt_hi_rd && !state_ff.buf_valid) begin
      nxt_state.buf_lo = state_ff.count[7:0];
    end
    if (cnt_hi_rd) begin
      nxt_state.buf_valid = 1'b1;
    end
    if (cnt_lo_rd) begin
      nxt_state.buf_valid = 1'b0;
    end
    // Register writes take effect at the access edge only.
    if (wr_access) begin
      case (idx)
        FRT_IDX_CTRL: nxt_state.ctrl = apb_req.pwdata[7:0] & FRT_CTRL_WMASK;
        FRT_IDX_CMP_HI: begin
          nxt_state.compare[15:8] = apb_req.pwdata[7:0];
          nxt_state.cmp_inhibit = 1'b1;
        end
        FRT_IDX_CMP_LO: begin
          nxt_state.compare[7:0] = apb_req.pwdata[7:0];
          nxt_state.cmp_inhibit = 1'b0;
          if (state_ff.ocf_arm) begin
            nxt_state.ocf = 1'b0;
            nxt_state.ocf_arm = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Start-up hold, then the divide-by-four prescaler and counter.
    // The counter steps on a rising pclk edge, i.e. as the bus clock
    // phase seen by software turns from low to high.
    if (!state_ff.started) begin
      nxt_state.start_cnt = state_ff.start_cnt + 16'h0001;
      if (state_ff.start_cnt == 16'(STARTUP_CYCLES - 1)) begin
        nxt_state.started = 1'b1;
      end
    end else begin
      nxt_state.psc = state_ff.psc + 2'h1;
      if (tick) begin
        nxt_state.count = state_ff.count + FRT_CNT_ONE;
      end
    end
    // Capture pin synchroniser; only stages two and three feed the edge test.
    nxt_state.cap_sync = {state_ff.cap_sync[1:0], capture_input_pin};
    if (cap_edge && !state_ff.cap_inhibit) begin
      nxt_state.capture = state_ff.count;
    end
    // Compare match moves the programmed level to the pin register.
    if (match) begin
      nxt_state.cmp_level = state_ff.ctrl[FRT_BIT_LEVEL];
    end
    // Flag sets win over any clear made above.
    if (cap_edge) begin
      nxt_state.icf = 1'b1;
    end
    if (match) begin
      nxt_state.ocf = 1'b1;
    end
    if (wrap) begin
      nxt_state.ovf = 1'b1;
    end
    // One combined request; each source gated by its enable.
    // The request is registered, so it trails its flag by one cycle.
    nxt_state.irq = (state_ff.icf && state_ff.ctrl[FRT_BIT_CAP_IE])
      || (state_ff.ocf && state_ff.ctrl[FRT_BIT_CMP_IE])
      || (state_ff.ovf && state_ff.ctrl[FRT_BIT_OVF_IE]);
  end

  // State register; a low clock enable freezes everything.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= FRT_STATE_RST;
    end else if (pclk_en) begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from the state register.
  assign apb_rsp = state_ff.rsp;
  assign compare_output_pin = state_ff.cmp_level;
  assign timer_irq = state_ff.irq;

  // Checks on the core's own behaviour.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_hi_read;
    pclk_en && cnt_hi_rd;
  endsequence

  sequence s_lo_read;
    pclk_en && cnt_lo_rd;
  endsequence

  property p_count_step;
    pclk_en && tick |=> state_ff.count == $past(state_ff.count) + FRT_CNT_ONE;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step by one");

  property p_count_hold;
    pclk_en && !tick |=> state_ff.count == $past(state_ff.count);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved without a tick");

  property p_startup_hold;
    !state_ff.started |-> state_ff.count == FRT_CNT_RST && state_ff.psc == 2'h0;
  endproperty
  a_startup_hold: assert property (p_startup_hold) else $error("counter ran before start-up");

  property p_wrap_flag;
    pclk_en && wrap |=> state_ff.ovf && state_ff.count == 16'h0000;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set overflow flag");

  property p_alt_keeps_ovf;
    pclk_en && rd_setup && idx == FRT_IDX_ALT_LO && state_ff.ovf |=> state_ff.ovf;
  endproperty
  a_alt_keeps_ovf: assert property (p_alt_keeps_ovf) else $error("alternate low read cleared flag");

  property p_hi_buffer;
    s_hi_read |=> state_ff.buf_valid
      && state_ff.buf_lo == ($past(state_ff.buf_valid) ? $past(state_ff.buf_lo) : $past(state_ff.count[7:0]));
  endproperty
  a_hi_buffer: assert property (p_hi_buffer) else $error("high read did not freeze buffer");

  property p_live_lo;
    s_lo_read and (state_ff.buf_valid == 1'b0) |=> apb_rsp.prdata[7:0] == $past(state_ff.count[7:0])
      && apb_rsp.pready && !state_ff.buf_valid;
  endproperty
  a_live_lo: assert property (p_live_lo) else $error("lone low read not live");

  property p_ctrl_read;
    pclk_en && rd_setup && idx == FRT_IDX_CTRL |=> apb_rsp.pready && apb_rsp.prdata[4:2] == 3'h0
      && apb_rsp.prdata[31:8] == 24'h00_0000;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read shows reserved bits");

  property p_capture;
    pclk_en && cap_edge && !state_ff.cap_inhibit |=> state_ff.capture == $past(state_ff.count) && state_ff.icf;
  endproperty
  a_capture: assert property (p_capture) else $error("capture edge not latched");

  property p_compare_pin;
    pclk_en && match |=> compare_output_pin == $past(state_ff.ctrl[FRT_BIT_LEVEL]) && state_ff.ocf;
  endproperty
  a_compare_pin: assert property (p_compare_pin) else $error("compare pin not updated");

  property p_ovf_irq;
    pclk_en && state_ff.ovf && state_ff.ctrl[FRT_BIT_OVF_IE] |=> timer_irq;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow interrupt missing");

  property p_no_irq;
    pclk_en && !(state_ff.icf && state_ff.ctrl[FRT_BIT_CAP_IE]) && !(state_ff.ocf && state_ff.ctrl[FRT_BIT_CMP_IE])
      && !(state_ff.ovf && state_ff.ctrl[FRT_BIT_OVF_IE]) |=> !timer_irq;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("interrupt without enabled flag");

  // Every setup is answered at the next enabled edge; software never waits longer.
  property p_ready_next;
    pclk_en && setup |=> apb_rsp.pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("setup not answered in one cycle");

  // A control write keeps only the defined bits.
  property p_ctrl_write;
    pclk_en && wr_access && idx == FRT_IDX_CTRL |=> state_ff.ctrl == ($past(apb_req.pwdata[7:0]) & FRT_CTRL_WMASK);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

  // An armed primary low read clears the overflow flag unless a wrap lands at once.
  property p_ovf_clear;
    pclk_en && rd_setup && idx == FRT_IDX_CNT_LO && state_ff.ovf_arm && !wrap |=> !state_ff.ovf;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

  // While the capture high byte is pending the captured value must not move.
  property p_cap_hold;
    pclk_en && state_ff.cap_inhibit |=> state_ff.capture == $past(state_ff.capture);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture moved while inhibited");

  // A half-written compare value must never produce a match.
  property p_cmp_inhibit;
    state_ff.cmp_inhibit |-> !match;
  endproperty
  a_cmp_inhibit: assert property (p_cmp_inhibit) else $error("match while compare inhibited");

  // The capture flag is set on every valid edge, even when the transfer is held off.
  property p_cap_flag;
    pclk_en && cap_edge |=> state_ff.icf;
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("capture flag not set");
endmodule

// File: verilog/frt_pkg.sv
// Purpose: Constants and types shared by the free-running timer core.
// Assumes: APB index k sits at byte address 4*k.
// Notes: The whole core state is one packed struct declared here.
package frt_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] FRT_IDX_CTRL = 6'h12;
  localparam logic [5:0] FRT_IDX_STAT = 6'h13;
  localparam logic [5:0] FRT_IDX_CAP_HI = 6'h14;
  localparam logic [5:0] FRT_IDX_CAP_LO = 6'h15;
  localparam logic [5:0] FRT_IDX_CMP_HI = 6'h16;
  localparam logic [5:0] FRT_IDX_CMP_LO = 6'h17;
  localparam logic [5:0] FRT_IDX_CNT_HI = 6'h18;
  localparam logic [5:0] FRT_IDX_CNT_LO = 6'h19;
  localparam logic [5:0] FRT_IDX_ALT_HI = 6'h1A;
  localparam logic [5:0] FRT_IDX_ALT_LO = 6'h1B;
  // Control and status bit positions.
  localparam int FRT_BIT_CAP_IE = 7;
  localparam int FRT_BIT_CMP_IE = 6;
  localparam int FRT_BIT_OVF_IE = 5;
  localparam int FRT_BIT_EDGE = 1;
  localparam int FRT_BIT_LEVEL = 0;
  localparam int FRT_BIT_CAP_FLAG = 7;
  localparam int FRT_BIT_CMP_FLAG = 6;
  localparam int FRT_BIT_OVF_FLAG = 5;
  localparam logic [7:0] FRT_CTRL_WMASK = 8'hE3;
  // Counter values and timing.
  localparam logic [15:0] FRT_CNT_RST = 16'hFFFC;
  localparam logic [15:0] FRT_CNT_WRAP = 16'hFFFF;
  localparam logic [15:0] FRT_CNT_ONE = 16'h0001;
  localparam logic [1:0] FRT_PSC_LAST = 2'h3;
  localparam int FRT_CLK_NS = 50;
  localparam int FRT_STARTUP_DEF = 4096;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } frt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } frt_apb_rsp_t;

  typedef struct packed {
    logic [15:0] count;
    logic [1:0] psc;
    logic [15:0] start_cnt;
    logic started;
    logic [7:0] buf_lo;
    logic buf_valid;
    logic [7:0] ctrl;
    logic icf;
    logic ocf;
    logic ovf;
    logic icf_arm;
    logic ocf_arm;
    logic ovf_arm;
    logic [15:0] capture;
    logic cap_inhibit;
    logic [15:0] compare;
    logic cmp_inhibit;
    logic cmp_level;
    logic [2:0] cap_sync;
    logic irq;
    frt_apb_rsp_t rsp;
  } frt_state_t;

  localparam frt_state_t FRT_STATE_RST = '{count: FRT_CNT_RST, default: '0};
endpackage

// File: verif/frt_timer_test.sv
// Purpose: Self-checking bench for the free-running timer core over APB.
// Assumes: Byte address is four times the register index; start-up cut to 4 cycles.
// Notes: Count steps are judged from fixed bus spacing, never from absolute time.
`timescale 1ns/1ps
module frt_timer_test import frt_pkg::*;;
  logic pclk;
  logic presetn;
  logic pclk_en;
  logic capture_input_pin;
  logic compare_output_pin;
  logic timer_irq;
  frt_apb_req_t req;
  frt_apb_rsp_t rsp;
  int num_errors;
  int checks_done;
  logic [7:0] d;
  logic [7:0] l0;
  logic [7:0] l1;
  logic e;

  // A short start-up delay lets the first wrap come soon after each reset.
  frt_timer #(.STARTUP_CYCLES(4)) dut (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .apb_req(req),
    .apb_rsp(rsp),
    .capture_input_pin(capture_input_pin),
    .compare_output_pin(compare_output_pin),
    .timer_irq(timer_irq)
  );

  // Bus clock with a 50 ns period.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Counts every comparison and reports each mismatch on one line.
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", w, x, s);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One APB transfer, started just after a rising edge; the request stands until pready
  // is sampled high at a rising edge, where data is taken and a next setup may begin.
  // Two-byte reads in t_reset are issued back to back; t_buffer spaces them with 18 idle cycles.
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [7:0] rdv, output logic err);
    int n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: {24'h00_0000, wd}};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rdv = rsp.prdata[7:0];
    err = rsp.pslverr;
    chk("pready", rsp.pready, 1'b1);
  endtask

  task automatic rd(input logic [5:0] idx, output logic [7:0] v);
    apb(1'b0, idx, 8'h00, v, e);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v, d, e);
  endtask

  // Releases the bus; two setups n cycles apart are sampled n+2 edges apart.
  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge pclk);
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic wait_pin(input logic v);
    int n = 0;
    while (compare_output_pin !== v && n < 400) begin
      @(negedge pclk);
      n++;
    end
    chk("compare pin", compare_output_pin, v);
    @(posedge pclk);
  endtask

  task automatic t_reset();
    do_reset();
    rd(FRT_IDX_CNT_LO, d);
    chk("count lo at reset", d, 8'hFC);
    rd(FRT_IDX_CTRL, d);
    chk("control at reset", d, 8'h00);
    rd(FRT_IDX_CNT_HI, d);
    chk("count hi at reset", d, 8'hFF);
    rd(FRT_IDX_CNT_LO, d);
  endtask

  // The wrap lands a few ticks after reset, so the flag is tested here.
  task automatic t_overflow();
    idle(40);
    rd(FRT_IDX_CNT_LO, d);
    rd(FRT_IDX_STAT, d);
    chk("overflow flag", d[5], 1'b1);
    chk("irq masked", timer_irq, 1'b0);
    wr(FRT_IDX_CTRL, 8'h20);
    idle(3);
    chk("overflow irq", timer_irq, 1'b1);
    rd(FRT_IDX_ALT_LO, d);
    rd(FRT_IDX_STAT, d);
    chk("flag after alt lo", d[5], 1'b1);
    rd(FRT_IDX_CNT_LO, d);
    rd(FRT_IDX_STAT, d);
    chk("flag after count lo", d[5], 1'b0);
    idle(2);
    chk("irq after clear", timer_irq, 1'b0);
  endtask

  task automatic t_ctrl();
    wr(FRT_IDX_CTRL, 8'hFF);
    rd(FRT_IDX_CTRL, d);
    chk("control readback", d, 8'hE3);
  endtask

  // Setups 40 cycles apart must see exactly ten ticks.
  task automatic t_live();
    rd(FRT_IDX_CNT_LO, l0);
    idle(38);
    rd(FRT_IDX_CNT_LO, l1);
    chk("live lo step", 8'(l1 - l0), 8'h0A);
  endtask

  // A second high read must not reload the frozen low byte.
  task automatic t_buffer();
    for (int v = 0; v < 2; v++) begin
      rd(v ? FRT_IDX_ALT_HI : FRT_IDX_CNT_HI, d);
      idle(18);
      rd(v ? FRT_IDX_ALT_HI : FRT_IDX_CNT_HI, d);
      idle(18);
      rd(v ? FRT_IDX_ALT_LO : FRT_IDX_CNT_LO, l0);
      rd(v ? FRT_IDX_ALT_LO : FRT_IDX_CNT_LO, l1);
      chk("buffered lo", 8'(l1 - l0) inside {8'h0A, 8'h0B}, 1'b1);
    end
  endtask

  task automatic t_refuse();
    apb(1'b0, 6'h20, 8'h00, d, e);
    chk("unmapped error", e, 1'b1);
    chk("unmapped data", d, 8'h00);
  endtask

  task automatic t_compare();
    do_reset();
    wr(FRT_IDX_CMP_HI, 8'h00);
    wr(FRT_IDX_CMP_LO, 8'h20);
    wr(FRT_IDX_CTRL, 8'h41);
    idle(1);
    chk("pin before match", compare_output_pin, 1'b0);
    wait_pin(1'b1);
    rd(FRT_IDX_STAT, d);
    chk("compare flag", d[6], 1'b1);
    chk("compare irq", timer_irq, 1'b1);
    wr(FRT_IDX_CMP_LO, 8'h30);
    idle(2);
    chk("irq after clear", timer_irq, 1'b0);
    wr(FRT_IDX_CTRL, 8'h40);
    idle(1);
    wait_pin(1'b0);
  endtask

  task automatic cap_edge(input logic lvl, input logic hit);
    rd(FRT_IDX_CNT_LO, l0);
    idle(1);
    capture_input_pin <= lvl;
    idle(8);
    rd(FRT_IDX_STAT, d);
    chk("capture flag", d[7], hit);
    chk("capture irq", timer_irq, hit);
    rd(FRT_IDX_CAP_LO, l1);
    if (hit) begin
      chk("capture value", 8'(l1 - l0) <= 8'h03, 1'b1);
    end
    idle(2);
    chk("irq after clear", timer_irq, 1'b0);
  endtask

  // Each edge polarity is tried with both settings of the edge select.
  task automatic t_capture();
    wr(FRT_IDX_CTRL, 8'h82);
    cap_edge(1'b1, 1'b1);
    cap_edge(1'b0, 1'b0);
    wr(FRT_IDX_CTRL, 8'h80);
    cap_edge(1'b1, 1'b0);
    cap_edge(1'b0, 1'b1);
  endtask

  // Main sequence.
  initial begin
    presetn = 1'b0;
    pclk_en = 1'b1;
    req = '0;
    capture_input_pin = 1'b0;
    num_errors = 0;
    checks_done = 0;
    t_reset();
    t_overflow();
    t_ctrl();
    t_live();
    t_buffer();
    t_refuse();
    t_compare();
    t_capture();
    stop_test();
  end

  // Cuts a hang short; the run itself needs only a few hundred cycles.
  initial begin
    #(20000 * 50);
    num_errors++;
    stop_test();
  end
endmodule
